/* sps_shift_reg.v */
// Operation
// - Eight cascaded stages, each with parallel output
// - Apart from clear, stages change only on clock rising edge
// - Either gated input low loads zero
// - Both gated inputs high load a one
// - Each later stage takes its predecessor's value
// - Clear low forces all stages low immediately
// - No rising edge means stages hold
// - Serial inputs sampled only at rising edge
`timescale 1ns/1ns
`include "sps_defines.vh"

module sps_shift_reg #(
   parameter WIDTH = `SPS_STAGES
) (
   input  wire             CLK,
   input  wire             RST,
   input  wire             CLEAR_N,
   input  wire             SHIFT_CLK,
   input  wire             SER_A,
   input  wire             SER_B,
   output wire [WIDTH-1:0] STAGE_OUT,
   output wire             SHIFT_READY,
   output wire [WIDTH-1:0] WORD_DATA,
   output wire             WORD_VALID,
   input  wire             WORD_READY
);

   // The stages follow the shift clock pin, sampled on CLK, so the fastest
   // shift is one every two CLK cycles.
   // Clear acts at once and without CLK; reset acts only on a CLK edge.
   // Every shift pushes the new parallel word into the buffer. Upstream
   // must hold the shift clock low while SHIFT_READY is low: a shift then
   // still moves the stages, but its word is dropped.
   // Clear leaves the buffer as it is, so words taken before a clear can
   // still be read afterwards.

   wire [WIDTH-1:0] stage_q;
   wire             shift_clk_q;
   wire             ready_q;
   wire             rise;
   wire             gated_bit;
   wire [WIDTH-1:0] shifted;
   wire             push;

   // Previous level of the shift clock pin; a pulse shorter than one
   // CLK period is not seen, which bounds the shift rate
   sps_edge u_edge (
      .clk   (CLK),
      .rst   (RST),
      .pin   (SHIFT_CLK),
      .pin_q (shift_clk_q)
   );

   assign rise      = SHIFT_CLK & ~shift_clk_q;
   // A low on either serial input forces a zero into the first stage
   assign gated_bit = SER_A & SER_B;
   assign shifted   = {stage_q[WIDTH-2:0], gated_bit};
   // Nothing is buffered under clear, so the word matches the stages
   assign push      = rise & ready_q & CLEAR_N;

   assign STAGE_OUT   = stage_q;
   assign SHIFT_READY = ready_q;

   genvar i;

   // Stage zero takes the gated bit, each later stage its neighbour
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_stage
         sps_stage u_stage (
            .clk     (CLK),
            .rst     (RST),
            .clear_n (CLEAR_N),
            .load    (rise),
            .d       (shifted[i]),
            .q       (stage_q[i])
         );
      end
   endgenerate

   // Parallel words wait here while the consumer stalls,
   // and leave in the order they were shifted
   sps_pair_buf #(
      .WIDTH (WIDTH)
   ) u_buf (
      .clk        (CLK),
      .rst        (RST),
      .push       (push),
      .push_data  (shifted),
      .push_ready (ready_q),
      .pop_data   (WORD_DATA),
      .pop_valid  (WORD_VALID),
      .pop_ready  (WORD_READY)
   );

endmodule // sps_shift_reg

// Registered copy of a pin level for edge detection
// The pin is taken as synchronous to CLK, so no synchroniser stands here
module sps_edge (
   input  wire clk,
   input  wire rst,
   input  wire pin,
   output wire pin_q
);

   reg sample_q;

   assign pin_q = sample_q;

   // Idle level after reset is low, so no false edge follows reset
   always @(posedge clk)
   begin
      if (rst)
         sample_q <= `SPS_CLR_BIT;
      else
         sample_q <= pin;
   end

endmodule // sps_edge

// One storage stage of the chain
// Reset is synchronous; clear is the only asynchronous control
module sps_stage #(
   parameter CLR_VALUE = `SPS_CLR_BIT
) (
   input  wire clk,
   input  wire rst,
   input  wire clear_n,
   input  wire load,
   input  wire d,
   output wire q
);

   reg bit_q;

   assign q = bit_q;

   // Clear acts without the clock and wins over reset and load
   always @(posedge clk or negedge clear_n)
   begin
      if (!clear_n)
         bit_q <= CLR_VALUE;
      else if (rst)
         bit_q <= CLR_VALUE;
      else if (load)
         bit_q <= d;
      else
         bit_q <= bit_q;
   end

endmodule // sps_stage

// Two-entry first-in first-out buffer; a push and a pop may share an edge
// count_q holds the number of stored words; head_q is always the
// oldest one and tail_q the younger one when two are held
module sps_pair_buf #(
   parameter WIDTH = `SPS_STAGES
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             push,
   input  wire [WIDTH-1:0] push_data,
   output wire             push_ready,
   output wire [WIDTH-1:0] pop_data,
   output wire             pop_valid,
   input  wire             pop_ready
);

   reg  [WIDTH-1:0] head_q;
   reg  [WIDTH-1:0] tail_q;
   reg  [1:0]       count_q;
   reg  [1:0]       count_d;
   reg              valid_q;
   reg              ready_q;

   wire             pop;

   assign pop        = valid_q & pop_ready;
   assign push_ready = ready_q;
   assign pop_data   = head_q;
   assign pop_valid  = valid_q;

   // Next occupancy from this edge's push and pop
   always @*
   begin
      count_d = count_q;
      if (push && !pop)
         count_d = count_q + 2'h1;
      else if (pop && !push)
         count_d = count_q - 2'h1;
   end

   // Flags are registered from the next count so they leave a flip-flop
   always @(posedge clk)
   begin
      if (rst)
      begin
         head_q  <= {WIDTH{`SPS_CLR_BIT}};
         tail_q  <= {WIDTH{`SPS_CLR_BIT}};
         count_q <= `SPS_CNT_EMPTY;
         valid_q <= 1'b0;
         ready_q <= 1'b1;
      end
      else
      begin
         count_q <= count_d;
         valid_q <= (count_d != `SPS_CNT_EMPTY);
         ready_q <= (count_d != `SPS_CNT_FULL);
         if (push && (count_q == `SPS_CNT_EMPTY ||
                      (count_q == `SPS_CNT_ONE && pop)))
            head_q <= push_data;
         else if (pop && count_q == `SPS_CNT_FULL)
            head_q <= tail_q;
         if (push && ((count_q == `SPS_CNT_ONE && !pop) ||
                      (count_q == `SPS_CNT_FULL && pop)))
            tail_q <= push_data;
      end
   end

endmodule // sps_pair_buf

/* sps_defines.vh */
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// Number of cascaded stages
`define SPS_STAGES     8
// Value every stage takes on clear or reset
`define SPS_CLR_WORD   8'h00
`define SPS_CLR_BIT    1'b0
// Buffer occupancy codes
`define SPS_CNT_EMPTY  2'h0
`define SPS_CNT_ONE    2'h1
`define SPS_CNT_FULL   2'h2

`endif

/* sps_src.sv */
`timescale 1ns/1ns
module sps_src (
   input  wire       clk,
   input  wire       req,
   input  wire [1:0] ab,
   output logic      sck = 1'b0,
   output logic      a = 1'b0,
   output logic      b = 1'b0
);
   // One shift clock pulse per request; the clock rests low between them
   always @(posedge clk)
   begin
      if (req && !sck)
      begin
         sck <= 1'b1;
         a   <= ab[1];
         b   <= ab[0];
      end
      else
         sck <= 1'b0;
   end
endmodule // sps_src

/* sps_shift_reg_checker.sv */
`timescale 1ns/1ns
module sps_chk (
   input wire       CLK,
   input wire       RST,
   input wire       CLEAR_N,
   input wire       SHIFT_CLK,
   input wire       SER_A,
   input wire       SER_B,
   input wire [7:0] STAGE_OUT,
   input wire       SHIFT_READY,
   input wire [7:0] WORD_DATA,
   input wire       WORD_VALID,
   input wire       WORD_READY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   shift_in_a: assert property ($rose(SHIFT_CLK) && CLEAR_N && !RST |=>
      RST || !CLEAR_N || STAGE_OUT == {$past(STAGE_OUT[6:0]), $past(SER_A & SER_B)})
      else $error("shift");
   stage_hold_a: assert property (!$rose(SHIFT_CLK) && !RST |=>
      RST || !CLEAR_N || $stable(STAGE_OUT)) else $error("hold");
   clear_low_a: assert property (!CLEAR_N |-> STAGE_OUT == 8'h00)
      else $error("clear");
   first_zero_a: assert property ($rose(SHIFT_CLK) && CLEAR_N && !RST && !(SER_A && SER_B)
      |=> RST || !CLEAR_N || !STAGE_OUT[0]) else $error("gate");
   clear_restart_a: assert property ($rose(CLEAR_N) |-> STAGE_OUT == 8'h00)
      else $error("restart");
   word_push_a: assert property ($rose(SHIFT_CLK) && CLEAR_N && !RST && SHIFT_READY &&
      !WORD_VALID |=> RST || !CLEAR_N || (WORD_VALID && WORD_DATA == STAGE_OUT))
      else $error("word");
   cover property ($rose(SHIFT_CLK) && SER_A && SER_B);
   cover property (!CLEAR_N);
   cover property ($rose(CLEAR_N));
   cover property (!SHIFT_READY && WORD_VALID && !WORD_READY);
endmodule // sps_chk
bind sps_shift_reg sps_chk chk (
   .CLK         (CLK),
   .RST         (RST),
   .CLEAR_N     (CLEAR_N),
   .SHIFT_CLK   (SHIFT_CLK),
   .SER_A       (SER_A),
   .SER_B       (SER_B),
   .STAGE_OUT   (STAGE_OUT),
   .SHIFT_READY (SHIFT_READY),
   .WORD_DATA   (WORD_DATA),
   .WORD_VALID  (WORD_VALID),
   .WORD_READY  (WORD_READY)
);

/* sps_shift_reg_test.sv */
`timescale 1ns/1ns
module sps_shift_reg_test;
   logic       CLK = 1'b0;
   logic       RST = 1'b1;
   logic       clr_n = 1'b1;
   logic       req = 1'b0;
   logic       rdy = 1'b1;
   logic [1:0] ab = 2'h0;
   logic [7:0] e = 8'h00;
   logic [7:0] w = 8'h00;
   wire        sck;
   wire        a;
   wire        b;
   wire  [7:0] so;
   wire  [7:0] wd;
   wire        wv;
   wire        sr;
   int         errors = 0;
   int         n_checks = 0;

   always #50 CLK = ~CLK;

   sps_src src (
      .clk (CLK),
      .req (req),
      .ab  (ab),
      .sck (sck),
      .a   (a),
      .b   (b)
   );

   sps_shift_reg dut (
      .CLK         (CLK),
      .RST         (RST),
      .CLEAR_N     (clr_n),
      .SHIFT_CLK   (sck),
      .SER_A       (a),
      .SER_B       (b),
      .STAGE_OUT   (so),
      .SHIFT_READY (sr),
      .WORD_DATA   (wd),
      .WORD_VALID  (wv),
      .WORD_READY  (rdy)
   );

   task cmp_stage(input logic [7:0] x);
      n_checks++;
      if (so !== x)
      begin
         errors++;
         $display("[FAIL] %0t stage outputs", $time);
      end
   endtask

   task cmp_word(input logic [7:0] x, input logic v);
      n_checks++;
      if (wd !== x || wv !== v)
      begin
         errors++;
         $display("[FAIL] %0t buffered word", $time);
      end
   endtask

   task cmp_ready(input logic r);
      n_checks++;
      if (sr !== r)
      begin
         errors++;
         $display("[FAIL] %0t shift ready", $time);
      end
   endtask

   // One shift clock pulse; the stages move at the third edge
   task shift_one(input logic [1:0] v);
      @(posedge CLK);
      req <= 1'b1;
      ab  <= v;
      @(posedge CLK);
      req <= 1'b0;
      @(posedge CLK);
      #1;
      if (clr_n)
         e = {e[6:0], v[1] & v[0]};
      cmp_stage(e);
   endtask

   task gating_test;
      shift_one(2'h3);
      cmp_word(e, 1'b1);
      shift_one(2'h2);
      shift_one(2'h1);
      shift_one(2'h0);
      shift_one(2'h3);
      shift_one(2'h3);
      shift_one(2'h3);
      shift_one(2'h3);
      cmp_stage(8'h8f);
      shift_one(2'h0);
      cmp_word(e, 1'b1);
      repeat (3) @(posedge CLK);
      #1;
      cmp_stage(e);
   endtask

   task stall_test;
      @(posedge CLK);
      rdy <= 1'b0;
      shift_one(2'h3);
      w = e;
      shift_one(2'h0);
      cmp_word(w, 1'b1);
      cmp_ready(1'b0);
      @(posedge CLK);
      rdy <= 1'b1;
      @(posedge CLK);
      #1;
      cmp_word(e, 1'b1);
      cmp_ready(1'b1);
      @(posedge CLK);
      #1;
      cmp_word(e, 1'b0);
   endtask

   task clear_test;
      w = e;
      @(posedge CLK);
      clr_n <= 1'b0;
      #1;
      cmp_stage(8'h00);
      e = 8'h00;
      shift_one(2'h3);
      cmp_word(w, 1'b0);
      @(posedge CLK);
      clr_n <= 1'b1;
      shift_one(2'h3);
      cmp_word(e, 1'b1);
   endtask

   task reset_test;
      shift_one(2'h3);
      @(posedge CLK);
      RST <= 1'b1;
      @(posedge CLK);
      RST <= 1'b0;
      #1;
      cmp_stage(8'h00);
      cmp_word(8'h00, 1'b0);
      cmp_ready(1'b1);
      e = 8'h00;
      shift_one(2'h3);
      cmp_word(e, 1'b1);
   endtask

   task wrap_up;
      if (errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      gating_test;
      stall_test;
      clear_test;
      reset_test;
      wrap_up;
   end

   initial
   begin
      #100000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up;
   end
endmodule // sps_shift_reg_test
